// [hdl/lvl1_defines.svh]
`ifndef LVL1_DEFINES_SVH
`define LVL1_DEFINES_SVH
// =====================================================
// Command codes
`define CMD_RESET 8'h00
`define CMD_ABORT 8'h01
`define CMD_ASSERT_ATN 8'h02
`define CMD_NEGATE_ACK 8'h03
`define CMD_DISCONNECT 8'h04
`define CMD_SET_DISC_IRQ 8'h0f
// =====================================================
// Status values after reset
`define STAT_RESET_BASIC 8'h00
`define STAT_RESET_ADV 8'h01
// =====================================================
// Selection abort timing
`define SEL_ABORT_US 200
`define CLK_MHZ 10
`define SEL_ABORT_CYC (`SEL_ABORT_US * `CLK_MHZ)
`define CNT_W 12
`define CNT_ZERO 12'h000
`define CNT_ONE 12'h001
`define TC_W 24
`endif

// [hdl/lvl1_pkg.sv]
package lvl1_pkg;
    // Controller connection state
    typedef enum logic [1:0] {
        ST_DISC,
        ST_TARGET,
        ST_INIT
    } conn_t;
    // Kind of level II command running
    typedef enum logic [2:0] {
        L2_NONE,
        L2_SELECT,
        L2_SEL_XFER,
        L2_SEND,
        L2_RECEIVE,
        L2_XFER_INFO,
        L2_RESELECT
    } l2_kind_t;
    // Abort sequencer states
    typedef enum logic [2:0] {
        AB_IDLE,
        AB_SEL_WAIT,
        AB_DRAIN,
        AB_DONE
    } ab_state_t;
    // Interrupt report
    typedef struct packed {
        logic reset_done;
        logic abort_paused;
        logic abort_success;
    } irq_t;
    // Level II status from sequencer
    typedef struct packed {
        l2_kind_t kind;
        logic active;
        logic arb_won;
        logic msg_out_last;
        logic identify_out;
        logic msg_in_done;
        logic rx_parity_err;
        logic bus_free;
        logic sel_atn_win;
    } l2_stat_t;
endpackage

// [hdl/scsi_level_one_command_unit.sv]
// Operation
// - Reset command reinitialises, disconnects
// - Reset completion interrupts, status 00 or 01
// - Abort accepted in all three states
// - Post-arbitration abort drops IDs, keeps SEL
// - No BSY in 200us: bus free, paused
// - Abort before arbitration won abandons immediately
// - Send abort drops request, drains FIFO first
// - Target abort keeps count, stays target
// - Initiator abort drains FIFO before interrupt
// - Initiator abort keeps count, stays initiator
// - Disconnect releases bus signals immediately
// - Disconnect terminates level II, goes disconnected
// - Assert ATN only while initiator
// - ATN auto-negated at three sequencer events
// - Select with ATN asserts ATN after win
// - Negate ACK releases held ACK
// - Host parity errors never affect ACK
// - Set disconnect interrupt during select-and-transfer
// - Level I accepted during level II, silent
// - Invalid level I commands are ignored
`timescale 1ns/1ps
`include "lvl1_defines.svh"
module scsi_level_one_command_unit (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic adv_mode_i,
    input wire lvl1_pkg::l2_stat_t l2_i,
    input wire logic bsy_in_i,
    input wire logic fifo_empty_i,
    input wire logic host_parity_err_i,
    input wire logic [`TC_W-1:0] xfer_left_i,
    output logic [1:0] conn_state_o,
    output logic l2_terminate_o,
    output logic fifo_clear_o,
    output logic sel_o,
    output logic id_bits_en_o,
    output logic atn_o,
    output logic ack_hold_o,
    output logic dma_request_line_en_o,
    output logic interrupt_on_disconnect_bit_o,
    output logic [7:0] scsi_status_o,
    output logic [`TC_W-1:0] xfer_count_o,
    output lvl1_pkg::irq_t irq_o
);
    lvl1_pkg::conn_t conn_q;
    lvl1_pkg::ab_state_t ab_q;
    logic [`CNT_W-1:0] tmo_q;
    logic is_reset;
    logic is_abort;
    logic is_disc;
    logic is_atn;
    logic is_nack;
    logic is_set_irq_disc;
    logic abort_ok;

    // =====================================================
    // Command decode and validity
    function automatic logic hit(input logic [7:0] c, input logic [7:0] k);
        hit = cmd_valid_i && (c == k);
    endfunction
    assign is_reset = hit(cmd_code_i, `CMD_RESET);
    assign is_abort = hit(cmd_code_i, `CMD_ABORT) && ab_q == lvl1_pkg::AB_IDLE;
    assign is_disc = hit(cmd_code_i, `CMD_DISCONNECT) && conn_q != lvl1_pkg::ST_DISC;
    assign is_atn = hit(cmd_code_i, `CMD_ASSERT_ATN) && conn_q == lvl1_pkg::ST_INIT;
    assign is_nack = hit(cmd_code_i, `CMD_NEGATE_ACK) && conn_q == lvl1_pkg::ST_INIT;
    assign is_set_irq_disc = hit(cmd_code_i, `CMD_SET_DISC_IRQ)
        && l2_i.kind == lvl1_pkg::L2_SEL_XFER
        && l2_i.active;
    assign abort_ok = is_abort && l2_i.active;

    // =====================================================
    // Connection state
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || is_reset) begin
            conn_q <= lvl1_pkg::ST_DISC;
        end else if (is_disc) begin
            conn_q <= lvl1_pkg::ST_DISC;
        end else if (ab_q == lvl1_pkg::AB_SEL_WAIT && tmo_q == `CNT_ONE && !bsy_in_i) begin
            conn_q <= lvl1_pkg::ST_DISC;
        end else if (ab_q == lvl1_pkg::AB_SEL_WAIT && bsy_in_i) begin
            // Answered reselection leaves us target, selection initiator
            conn_q <= (l2_i.kind == lvl1_pkg::L2_RESELECT) ? lvl1_pkg::ST_TARGET
                : lvl1_pkg::ST_INIT;
        end
        // Target and initiator aborts leave the state alone
    end
    assign conn_state_o = conn_q;

    // =====================================================
    // Abort sequencer
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || is_reset || is_disc) begin
            ab_q <= lvl1_pkg::AB_IDLE;
            tmo_q <= `CNT_ZERO;
        end else begin
            unique case (ab_q)
                lvl1_pkg::AB_IDLE: begin
                    if (abort_ok && conn_q == lvl1_pkg::ST_DISC && l2_i.arb_won) begin
                        ab_q <= lvl1_pkg::AB_SEL_WAIT;
                        tmo_q <= `CNT_W'(`SEL_ABORT_CYC);
                    end else if (abort_ok && conn_q != lvl1_pkg::ST_DISC) begin
                        ab_q <= lvl1_pkg::AB_DRAIN;
                    end
                end
                lvl1_pkg::AB_SEL_WAIT: begin
                    if (bsy_in_i || tmo_q == `CNT_ONE) begin
                        ab_q <= lvl1_pkg::AB_IDLE;
                    end
                    tmo_q <= tmo_q - `CNT_ONE;
                end
                lvl1_pkg::AB_DRAIN: begin
                    if (fifo_empty_i) begin
                        ab_q <= lvl1_pkg::AB_DONE;
                    end
                end
                lvl1_pkg::AB_DONE: begin
                    ab_q <= lvl1_pkg::AB_IDLE;
                end
                default: begin
                    ab_q <= lvl1_pkg::AB_IDLE;
                end
            endcase
        end
    end

    // =====================================================
    // Level II termination and FIFO clear
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            l2_terminate_o <= 1'b0;
            fifo_clear_o <= 1'b0;
        end else begin
            l2_terminate_o <= is_reset || is_disc
                || (abort_ok && conn_q == lvl1_pkg::ST_DISC && !l2_i.arb_won)
                || (ab_q == lvl1_pkg::AB_DONE);
            fifo_clear_o <= is_reset;
        end
    end

    // =====================================================
    // Selection signals during abort
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || is_reset || is_disc) begin
            sel_o <= 1'b0;
            id_bits_en_o <= 1'b0;
        end else if (ab_q == lvl1_pkg::AB_SEL_WAIT) begin
            sel_o <= !(bsy_in_i || tmo_q == `CNT_ONE);
            id_bits_en_o <= 1'b0;
        end else begin
            sel_o <= l2_i.active && l2_i.arb_won && conn_q == lvl1_pkg::ST_DISC;
            id_bits_en_o <= l2_i.active && l2_i.arb_won && conn_q == lvl1_pkg::ST_DISC;
        end
    end

    // =====================================================
    // ATN control
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || is_reset || is_disc) begin
            atn_o <= 1'b0;
        end else if (l2_i.msg_out_last || l2_i.identify_out || l2_i.bus_free) begin
            atn_o <= 1'b0;
        end else if (is_atn || (l2_i.sel_atn_win && l2_i.arb_won)) begin
            atn_o <= 1'b1;
        end
    end

    // =====================================================
    // ACK hold; host parity is deliberately not an input here
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || is_reset || is_disc) begin
            ack_hold_o <= 1'b0;
        end else if (l2_i.msg_in_done || l2_i.rx_parity_err) begin
            ack_hold_o <= 1'b1;
        end else if (is_nack) begin
            ack_hold_o <= 1'b0;
        end
    end

    // =====================================================
    // Data request gate for send aborts
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || is_reset) begin
            dma_request_line_en_o <= 1'b1;
        end else if (abort_ok && l2_i.kind == lvl1_pkg::L2_SEND) begin
            dma_request_line_en_o <= 1'b0;
        end else if (ab_q == lvl1_pkg::AB_IDLE) begin
            dma_request_line_en_o <= 1'b1;
        end
    end

    // =====================================================
    // Interrupt on disconnect bit
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || is_reset) begin
            interrupt_on_disconnect_bit_o <= 1'b0;
        end else if (is_set_irq_disc) begin
            interrupt_on_disconnect_bit_o <= 1'b1;
        end
    end

    // =====================================================
    // Status, transfer count and interrupts
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            scsi_status_o <= `STAT_RESET_BASIC;
            xfer_count_o <= '0;
            irq_o <= '0;
        end else begin
            irq_o <= '0;
            if (is_reset) begin
                scsi_status_o <= adv_mode_i ? `STAT_RESET_ADV : `STAT_RESET_BASIC;
                xfer_count_o <= '0;
                irq_o.reset_done <= 1'b1;
            end else if (ab_q == lvl1_pkg::AB_SEL_WAIT && bsy_in_i) begin
                irq_o.abort_success <= 1'b1;
            end else if (ab_q == lvl1_pkg::AB_SEL_WAIT && tmo_q == `CNT_ONE) begin
                irq_o.abort_paused <= 1'b1;
            end else if (ab_q == lvl1_pkg::AB_DONE) begin
                xfer_count_o <= xfer_left_i;
                irq_o.abort_paused <= 1'b1;
            end
        end
    end

    // =====================================================
    // Checks
    property p_reset_irq;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        is_reset |=> irq_o.reset_done && conn_q == lvl1_pkg::ST_DISC;
    endproperty
    a_reset_irq: assert property (p_reset_irq) else $error("reset without interrupt");
    property p_pre_arb;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        abort_ok && conn_q == lvl1_pkg::ST_DISC && !l2_i.arb_won
            |=> l2_terminate_o && ab_q == lvl1_pkg::AB_IDLE && irq_o == '0;
    endproperty
    a_pre_arb: assert property (p_pre_arb) else $error("early abort not immediate");
    property p_sel_keep;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (ab_q == lvl1_pkg::AB_SEL_WAIT && !bsy_in_i && tmo_q > `CNT_ONE && !is_reset && !is_disc)
            |=> sel_o && !id_bits_en_o;
    endproperty
    a_sel_keep: assert property (p_sel_keep) else $error("sel dropped early");
    property p_timeout;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(ab_q == lvl1_pkg::AB_SEL_WAIT) |-> tmo_q == `CNT_W'(`SEL_ABORT_CYC);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout too short");
    property p_tmo_step;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ab_q == lvl1_pkg::AB_SEL_WAIT && !bsy_in_i && tmo_q != `CNT_ONE && !is_reset && !is_disc
            |=> ab_q == lvl1_pkg::AB_SEL_WAIT && tmo_q == $past(tmo_q) - `CNT_ONE;
    endproperty
    a_tmo_step: assert property (p_tmo_step) else $error("selection wait cut short");
    property p_disc;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        is_disc |=> conn_q == lvl1_pkg::ST_DISC && !atn_o && !sel_o && l2_terminate_o;
    endproperty
    a_disc: assert property (p_disc) else $error("disconnect incomplete");
    property p_atn_invalid;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        conn_q != lvl1_pkg::ST_INIT && !atn_o && !l2_i.sel_atn_win |=> !atn_o;
    endproperty
    a_atn_invalid: assert property (p_atn_invalid) else $error("atn outside initiator");
    property p_atn_free;
        @(posedge sys_clk_i) disable iff (sys_rst_i) l2_i.bus_free |=> !atn_o;
    endproperty
    a_atn_free: assert property (p_atn_free) else $error("atn kept at bus free");
    property p_sel_atn;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        l2_i.sel_atn_win && l2_i.arb_won && !l2_i.msg_out_last && !l2_i.identify_out
            && !l2_i.bus_free && !is_reset && !is_disc |=> atn_o;
    endproperty
    a_sel_atn: assert property (p_sel_atn) else $error("atn missing after win");
    property p_host_par;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        host_parity_err_i && !l2_i.msg_in_done && !l2_i.rx_parity_err && !is_nack && !is_reset
            && !is_disc |=> ack_hold_o == $past(ack_hold_o);
    endproperty
    a_host_par: assert property (p_host_par) else $error("host parity moved ack");
    property p_irq_quiet;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        is_set_irq_disc && ab_q == lvl1_pkg::AB_IDLE
            |=> interrupt_on_disconnect_bit_o && irq_o == '0;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("level one interrupted");
    property p_send_gate;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        abort_ok && l2_i.kind == lvl1_pkg::L2_SEND |=> !dma_request_line_en_o;
    endproperty
    a_send_gate: assert property (p_send_gate) else $error("request kept in abort");
    property p_count;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ab_q == lvl1_pkg::AB_DONE && !is_reset
            |=> xfer_count_o == $past(xfer_left_i) && irq_o.abort_paused;
    endproperty
    a_count: assert property (p_count) else $error("count not captured");
    property p_nack;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        is_nack && !l2_i.msg_in_done && !l2_i.rx_parity_err |=> !ack_hold_o;
    endproperty
    a_nack: assert property (p_nack) else $error("ack not released");
    property p_drain;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ab_q == lvl1_pkg::AB_DRAIN && !fifo_empty_i |=> ab_q != lvl1_pkg::AB_DONE;
    endproperty
    a_drain: assert property (p_drain) else $error("abort before drain");
    property p_state_keep;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ab_q == lvl1_pkg::AB_DONE && !is_reset && !is_disc |=> conn_q == $past(conn_q);
    endproperty
    a_state_keep: assert property (p_state_keep) else $error("abort left state");
    c_sel_abort: cover property (@(posedge sys_clk_i) ab_q == lvl1_pkg::AB_SEL_WAIT ##1 bsy_in_i);
    c_drain: cover property (@(posedge sys_clk_i) ab_q == lvl1_pkg::AB_DONE);
    c_irq_on_disc: cover property (@(posedge sys_clk_i) is_set_irq_disc);
    c_target: cover property (@(posedge sys_clk_i)
        ab_q == lvl1_pkg::AB_DRAIN && conn_q == lvl1_pkg::ST_TARGET);
endmodule

// [test/scsi_far_end.sv]
`timescale 1ns/1ps
// ==========================================
// Far bus side: selected target and FIFO sink
module scsi_far_end (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sel_i,
    input wire logic id_en_i,
    input wire logic [11:0] resp_i,
    input wire logic load_i,
    input wire logic [7:0] fill_i,
    output logic bsy_o,
    output logic fifo_empty_o
);
    logic [11:0] wait_q;
    logic [7:0] level_q;

    // Cycles spent in selection with IDs removed
    always_ff @(posedge clk_i) begin
        if (rst_i || !sel_i) begin
            wait_q <= 12'h000;
        end else if (!id_en_i && wait_q != 12'hfff) begin
            wait_q <= wait_q + 12'h001;
        end
    end

    // Target answers after resp_i cycles, never when zero
    assign bsy_o = (resp_i != 12'h000) && sel_i && (wait_q >= resp_i);

    // FIFO contents drain one byte a cycle to their destination
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_q <= 8'h00;
        end else if (load_i) begin
            level_q <= fill_i;
        end else if (level_q != 8'h00) begin
            level_q <= level_q - 8'h01;
        end
    end

    assign fifo_empty_o = (level_q == 8'h00);
endmodule

// [test/scsi_level_one_command_unit_test.sv]
`timescale 1ns/1ps
module scsi_level_one_command_unit_test;
    logic clk = 1'b0, rst = 1'b1, cv = 1'b0, adv = 1'b0, hpe = 1'b0, ld = 1'b0;
    logic [7:0] code = 8'h00, fill = 8'h00;
    logic [11:0] resp = 12'h000;
    logic [23:0] left = 24'h000000;
    lvl1_pkg::l2_stat_t l2 = '0;
    logic bsy, fe, term, fclr, sel, iden, atn, ack, dreq, iod;
    logic [1:0] conn;
    logic [7:0] stat;
    logic [23:0] cnt;
    lvl1_pkg::irq_t irq;
    int fails = 0, samples_checked = 0, n;

    scsi_level_one_command_unit dut (.sys_clk_i(clk), .sys_rst_i(rst), .cmd_valid_i(cv),
        .cmd_code_i(code), .adv_mode_i(adv), .l2_i(l2), .bsy_in_i(bsy), .fifo_empty_i(fe),
        .host_parity_err_i(hpe), .xfer_left_i(left), .conn_state_o(conn),
        .l2_terminate_o(term), .fifo_clear_o(fclr), .sel_o(sel), .id_bits_en_o(iden),
        .atn_o(atn), .ack_hold_o(ack), .dma_request_line_en_o(dreq),
        .interrupt_on_disconnect_bit_o(iod), .scsi_status_o(stat), .xfer_count_o(cnt),
        .irq_o(irq));

    scsi_far_end far (.clk_i(clk), .rst_i(rst), .sel_i(sel), .id_en_i(iden), .resp_i(resp),
        .load_i(ld), .fill_i(fill), .bsy_o(bsy), .fifo_empty_o(fe));

    // ==========================================
    // Clock, helpers
    initial forever #50 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic cmd(input logic [7:0] c);
        code = c;
        cv = 1'b1;
        tick(1);
        cv = 1'b0;
    endtask

    // Bounded wait for any interrupt pulse
    task automatic wait_irq();
        n = 0;
        while (irq === 3'b000 && n < 2500) begin
            tick(1);
            n++;
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        for (int a = 0; a < 2; a++) begin
            adv = a[0];
            cmd(8'h00);
            chk(irq.reset_done, 1);
            chk(stat, {7'h00, adv});
            chk({conn, fclr}, 3'b001);
            tick(1);
            chk(irq, 3'b000);
        end
        $display("test reset done");
    endtask

    task automatic t_invalid();
        for (int c = 1; c < 5; c++) begin
            cmd(c[7:0]);
            chk({conn, atn, ack, irq, term}, 9'h000);
            tick(1);
        end
        $display("test invalid done");
    endtask

    task automatic t_select();
        l2.kind = lvl1_pkg::L2_SELECT;
        l2.active = 1'b1;
        cmd(8'h01);
        chk({term, irq}, 4'b1000);
        l2.arb_won = 1'b1;
        tick(1);
        for (int r = 0; r < 2; r++) begin
            resp = r ? 12'd40 : 12'd0;
            l2.active = 1'b1;
            cmd(8'h01);
            tick(1);
            chk({sel, iden}, 2'b10);
            wait_irq();
            chk(irq, r ? 3'b001 : 3'b010);
            chk(r ? n < 60 : n >= 1995, 1);
            l2.active = 1'b0;
            tick(1);
            chk(sel, 0);
        end
        chk(conn, 2);
        l2 = '0;
        $display("test select abort done");
    endtask

    task automatic t_initiator();
        cmd(8'h02);
        tick(1);
        chk(atn, 1);
        l2.bus_free = 1'b1;
        tick(1);
        l2.bus_free = 1'b0;
        tick(1);
        chk(atn, 0);
        l2.kind = lvl1_pkg::L2_SEL_XFER;
        l2.active = 1'b1;
        cmd(8'h0f);
        chk({iod, irq}, 4'b1000);
        l2.rx_parity_err = 1'b1;
        tick(1);
        l2.rx_parity_err = 1'b0;
        tick(1);
        chk(ack, 1);
        hpe = 1'b1;
        tick(2);
        chk(ack, 1);
        hpe = 1'b0;
        cmd(8'h02);
        tick(1);
        cmd(8'h03);
        tick(1);
        chk({ack, atn}, 2'b01);
        $display("test initiator done");
    endtask

    task automatic t_abort_disc();
        l2.kind = lvl1_pkg::L2_XFER_INFO;
        left = 24'h000123;
        fill = 8'h08;
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
        cmd(8'h01);
        wait_irq();
        chk({irq, n >= 6}, 4'b0101);
        tick(1);
        chk(cnt, 24'h000123);
        chk(conn, 2);
        cmd(8'h04);
        chk({term, conn, atn, sel}, 5'b10000);
        l2 = '0;
        tick(1);
        $display("test abort and disconnect done");
    endtask

    // Answered reselection, then send abort as target
    task automatic t_target();
        l2.kind = lvl1_pkg::L2_RESELECT;
        l2.active = 1'b1;
        l2.arb_won = 1'b1;
        resp = 12'h003;
        cmd(8'h01);
        wait_irq();
        chk(irq, 3'b001);
        l2 = '0;
        l2.kind = lvl1_pkg::L2_SEND;
        l2.active = 1'b1;
        tick(1);
        chk(conn, 1);
        left = 24'h000040;
        fill = 8'h05;
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
        cmd(8'h01);
        chk(dreq, 0);
        wait_irq();
        chk({irq, fe, dreq}, 5'b01010);
        tick(1);
        chk({cnt, conn, dreq}, {24'h000040, 2'h1, 1'b1});
        l2 = '0;
        $display("test target abort done");
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        tick(2);
        rst = 1'b0;
        t_reset();
        t_invalid();
        t_select();
        t_initiator();
        t_abort_disc();
        t_target();
        tally_and_finish();
    end

    initial begin
        #(6000 * 100);
        fails++;
        tally_and_finish();
    end
endmodule
